// *** src/phy_coding_path.sv ***
// transmit and receive coding path with clock strobe synthesis
`timescale 1ns/100ps
// Notes on behaviour
// R01: transmit nibbles from the MAC are shifted out as a serial line bit stream.
// R02: transmit data is 4B/5B coded first and the code stream is then scrambled.
// R03: the scrambled stream is turned into NRZI and then driven as three-level MLT3.
// R04: received MLT3 levels are turned back into an NRZI stream before decoding.
// R05: a bit clock is recovered from the transitions of the received NRZI stream.
// R06: the recovered bit clock samples the NRZI stream and turns it into NRZ.
// R07: the received NRZ stream is descrambled first and then 4B/5B decoded.
// R08: decoded bits are gathered into nibbles and handed to the MAC receive side.
// R09: strobes at the 125, 31.25, 25 and 10 MHz rates are produced for timing.
// R10: outside RMII mode all timing follows the 25 MHz reference input; the code uses it only to gate transmit pacing and strobes.
// R11: in RMII mode the outside party supplies a 50 MHz reference that all timing follows; the code uses it only to gate transmit pacing and strobes.
// R12: scrambling uses an 11-bit LFSR of period 2047 and the receiver uses the same sequence.
// R13: fiber mode bypasses scrambler, descrambler and MLT3 coding both ways.
// R14: NRZI toggles on a one and holds on a zero; MLT3 steps 0,+1,0,-1 on each toggle.
// R15: the standard code-group table with idle and delimiters is used; bad groups flag errors.
module phy_coding_path
  import phy_coding_pkg::*;
#(
  parameter int OVS = OVS_DEFAULT
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       rmii_mode,
  input  wire logic       fx_mode,
  input  wire logic       ref_clk_25m,
  input  wire logic       ref_clk_50m,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire tx_nibble_t tx_word,
  output mlt3_t           line_tx,
  output logic            fx_tx_bit,
  input  wire mlt3_t      line_rx,
  input  wire logic       fx_rx_bit,
  output rx_nibble_t      rx_word,
  output logic            rx_valid,
  output logic            rx_code_err,
  output logic            rx_locked,
  output logic            ref_ok,
  output logic            tick_125m,
  output logic            tick_31m25,
  output logic            tick_25m,
  output logic            tick_10m
);
  localparam int PW = $clog2(OVS);

  typedef enum {TX_IDLE, TX_K, TX_DATA, TX_T, TX_R} tx_state_t;
  typedef enum {RX_HUNT, RX_FRAME} rx_state_t;

  // pin synchronisers: stage one feeds stage two only
  logic [1:0] rmii_sy, fx_sy, r25_sy, r50_sy, fxrx_sy;
  mlt3_t      lrx_s1, lrx_s2;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rmii_sy <= '0;
      fx_sy   <= '0;
      r25_sy  <= '0;
      r50_sy  <= '0;
      fxrx_sy <= '0;
      lrx_s1  <= MLT3_ZERO;
      lrx_s2  <= MLT3_ZERO;
    end else begin
      rmii_sy <= {rmii_sy[0], rmii_mode};
      fx_sy   <= {fx_sy[0], fx_mode};
      r25_sy  <= {r25_sy[0], ref_clk_25m};
      r50_sy  <= {r50_sy[0], ref_clk_50m};
      fxrx_sy <= {fxrx_sy[0], fx_rx_bit};
      lrx_s1  <= line_rx;
      lrx_s2  <= lrx_s1;
    end
  end
  logic fx;
  assign fx = fx_sy[1];

  // reference watchdog: transmit bit pacing and strobes stop when the selected reference is still
  logic       ref_prev;
  logic       ref_sel;
  logic [4:0] ref_idle;
  // R10: 25 MHz reference in normal mode
  // R11: 50 MHz reference in RMII mode
  assign ref_sel = rmii_sy[1] ? r50_sy[1] : r25_sy[1];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_prev <= 1'b0;
      ref_idle <= '0;
      ref_ok   <= 1'b0;
    end else begin
      ref_prev <= ref_sel;
      if (ref_sel != ref_prev) begin
        ref_idle <= '0;
        ref_ok   <= 1'b1;
      end else if (ref_idle == 5'(REF_TIMEOUT_CYC - 1)) begin
        ref_ok   <= 1'b0;
      end else begin
        ref_idle <= ref_idle + 5'h01;
      end
    end
  end

  // line bit pacing; one line bit per OVS system clocks
  logic [PW-1:0] ovs_cnt;
  logic          bit_tick;
  assign bit_tick = ref_ok && (ovs_cnt == PW'(OVS - 1));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovs_cnt <= '0;
    end else if (!ref_ok || bit_tick) begin
      ovs_cnt <= '0;
    end else begin
      ovs_cnt <= ovs_cnt + PW'(1);
    end
  end

  // R09: rate strobes derived from the bit rate
  logic [2:0] div4, div5;
  logic [4:0] acc10;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div4       <= '0;
      div5       <= '0;
      acc10      <= '0;
      tick_125m  <= 1'b0;
      tick_31m25 <= 1'b0;
      tick_25m   <= 1'b0;
      tick_10m   <= 1'b0;
    end else begin
      tick_125m  <= bit_tick;
      tick_31m25 <= bit_tick && (div4 == 3'(BITS_PER_31M25 - 1));
      tick_25m   <= bit_tick && (div5 == 3'(BITS_PER_25M - 1));
      tick_10m   <= bit_tick && (acc10 >= 5'(HALF_BITS_10M - 2));
      if (bit_tick) begin
        div4  <= (div4 == 3'(BITS_PER_31M25 - 1)) ? 3'h0 : div4 + 3'h1;
        div5  <= (div5 == 3'(BITS_PER_25M - 1)) ? 3'h0 : div5 + 3'h1;
        // 12.5 bits per strobe: alternate spacing of 12 and 13
        acc10 <= (acc10 >= 5'(HALF_BITS_10M - 2)) ? acc10 + 5'h02 - 5'(HALF_BITS_10M)
                                                  : acc10 + 5'h02;
      end
    end
  end

  // transmit buffer: a stalled encoder holds the MAC off without loss
  logic       buf_valid;
  logic       buf_ready;
  tx_nibble_t buf_word;
  two_entry_buffer #(.W($bits(tx_nibble_t))) tx_buf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_word),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_word)
  );

  tx_state_t       tx_state, next_tx_state;
  logic [CG_W-1:0] tx_shift, next_group;
  logic [2:0]      tx_pos;
  logic            tx_load, tx_pop;
  assign tx_load   = bit_tick && (tx_pos == 3'(CG_W - 1));
  assign buf_ready = tx_load && tx_pop;

  // R15: group selection with delimiters and idle
  always_comb begin
    next_group    = CG_IDLE;
    next_tx_state = tx_state;
    tx_pop        = 1'b0;
    unique case (tx_state)
      TX_IDLE: begin
        if (buf_valid) begin
          next_group    = CG_J;
          next_tx_state = TX_K;
        end
      end
      TX_K: begin
        next_group    = CG_K;
        next_tx_state = TX_DATA;
      end
      TX_DATA: begin
        // an underrun inside a frame is sent as an error group
        next_group = CG_H;
        if (buf_valid) begin
          tx_pop     = 1'b1;
          // R02: 4B/5B coding ahead of the scrambler
          next_group = buf_word.er ? CG_H : enc_4b5b(buf_word.d);
          if (buf_word.last) begin
            next_tx_state = TX_T;
          end
        end
      end
      TX_T: begin
        next_group    = CG_T;
        next_tx_state = TX_R;
      end
      TX_R: begin
        next_group    = CG_R;
        next_tx_state = TX_IDLE;
      end
    endcase
  end

  // R01: code groups shifted out msb first, one per five line bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
      tx_shift <= CG_IDLE;
      tx_pos   <= '0;
    end else if (tx_load) begin
      tx_state <= next_tx_state;
      tx_shift <= next_group;
      tx_pos   <= '0;
    end else if (bit_tick) begin
      tx_shift <= {tx_shift[CG_W-2:0], 1'b0};
      tx_pos   <= tx_pos + 3'h1;
    end
  end

  logic [LFSR_W-1:0] tx_lfsr;
  logic              tx_line_bit;
  logic              tx_nrzi;
  logic [1:0]        tx_phase, next_tx_phase;
  // R02: scrambler after the coder
  // R13: fiber skips the scrambler
  assign tx_line_bit   = fx ? tx_shift[CG_W-1] : tx_shift[CG_W-1] ^ key_bit(tx_lfsr);
  assign next_tx_phase = tx_line_bit ? tx_phase + 2'h1 : tx_phase;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_lfsr   <= LFSR_SEED;
      tx_nrzi   <= 1'b0;
      tx_phase  <= 2'h0;
      line_tx   <= MLT3_ZERO;
      fx_tx_bit <= 1'b0;
    end else if (bit_tick) begin
      // R12: 11-bit maximal length keystream
      tx_lfsr   <= {tx_lfsr[LFSR_W-2:0], key_bit(tx_lfsr)};
      // R03: nrz to nrzi then mlt3
      // R14: toggle on one, step level cycle on toggle
      tx_nrzi   <= tx_nrzi ^ tx_line_bit;
      fx_tx_bit <= tx_nrzi ^ tx_line_bit;
      tx_phase  <= next_tx_phase;
      // R13: no mlt3 drive in fiber mode
      line_tx   <= fx ? MLT3_ZERO : mlt3_level(next_tx_phase);
    end
  end

  // receive front end
  mlt3_t         lrx_prev;
  logic          rx_nrzi, rx_nrzi_prev, next_rx_nrzi, sampled_nrzi;
  logic [PW-1:0] rx_phase;
  logic          rx_tick, nrz_bit;
  // R04: a level change on the mlt3 line is an nrzi toggle
  // R13: fiber carries nrzi directly
  assign next_rx_nrzi = fx ? fxrx_sy[1] : rx_nrzi ^ (lrx_s2 != lrx_prev);
  // R05: sample point placed half a bit after each transition
  assign rx_tick = (rx_phase == PW'(OVS / 2));
  // R06: nrzi change since last sample is a one
  assign nrz_bit = rx_nrzi ^ sampled_nrzi;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrx_prev     <= MLT3_ZERO;
      rx_nrzi      <= 1'b0;
      rx_nrzi_prev <= 1'b0;
      sampled_nrzi <= 1'b0;
      rx_phase     <= '0;
    end else begin
      lrx_prev     <= lrx_s2;
      rx_nrzi      <= next_rx_nrzi;
      rx_nrzi_prev <= rx_nrzi;
      if (rx_nrzi != rx_nrzi_prev) begin
        rx_phase <= '0;
      end else if (rx_phase == PW'(OVS - 1)) begin
        rx_phase <= '0;
      end else begin
        rx_phase <= rx_phase + PW'(1);
      end
      if (rx_tick) begin
        sampled_nrzi <= rx_nrzi;
      end
    end
  end

  // descrambler locks by loading the idle keystream, then free runs
  logic [LFSR_W-1:0] rx_lfsr;
  logic [5:0]        match_cnt;
  logic              scr_locked, desc_bit;
  // R07: descramble ahead of the decoder
  assign desc_bit  = fx ? nrz_bit : nrz_bit ^ key_bit(rx_lfsr);
  assign rx_locked = fx || scr_locked;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_lfsr    <= LFSR_SEED;
      match_cnt  <= '0;
      scr_locked <= 1'b0;
    end else if (rx_tick) begin
      // R12: same sequence as the transmitter
      if (scr_locked) begin
        rx_lfsr <= {rx_lfsr[LFSR_W-2:0], key_bit(rx_lfsr)};
      end else begin
        rx_lfsr <= {rx_lfsr[LFSR_W-2:0], ~nrz_bit};
        if (key_bit(rx_lfsr) == ~nrz_bit) begin
          match_cnt  <= match_cnt + 6'h01;
          scr_locked <= (match_cnt == 6'(LOCK_MATCH_BITS - 1));
        end else begin
          match_cnt <= '0;
        end
      end
    end
  end

  // alignment on J K, then decode each five bits
  rx_state_t         rx_state;
  logic [2*CG_W-1:0] rx_win, next_win;
  logic [2:0]        rx_cnt;
  decoded_t          dec;
  assign next_win = {rx_win[2*CG_W-2:0], desc_bit};
  assign dec      = dec_5b4b(next_win[CG_W-1:0]);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state    <= RX_HUNT;
      rx_win      <= '0;
      rx_cnt      <= '0;
      rx_word     <= '0;
      rx_valid    <= 1'b0;
      rx_code_err <= 1'b0;
    end else begin
      rx_valid    <= 1'b0;
      rx_code_err <= 1'b0;
      if (rx_tick && rx_locked) begin
        rx_win <= next_win;
        unique case (rx_state)
          RX_HUNT: begin
            if (next_win == {CG_J, CG_K}) begin
              rx_state <= RX_FRAME;
              rx_cnt   <= '0;
            end
          end
          RX_FRAME: begin
            rx_cnt <= (rx_cnt == 3'(CG_W - 1)) ? 3'h0 : rx_cnt + 3'h1;
            if (rx_cnt == 3'(CG_W - 1)) begin
              // R08: nibble handed to the MAC
              rx_valid <= 1'b1;
              if (next_win[CG_W-1:0] == CG_T) begin
                rx_word  <= '0;
                rx_state <= RX_HUNT;
              end else if (dec.ok) begin
                rx_word  <= '{dv: 1'b1, er: 1'b0, d: dec.d};
              end else begin
                // R15: bad group flagged; idle inside a frame also ends it
                rx_word     <= '{dv: 1'b1, er: 1'b1, d: '0};
                rx_code_err <= 1'b1;
                if (next_win[CG_W-1:0] == CG_IDLE) begin
                  rx_state <= RX_HUNT;
                end
              end
            end
          end
        endcase
      end
    end
  end
endmodule

// *** src/phy_coding_pkg.sv ***
// constants, carriers and coding functions of the 100 Mb/s coding path
package phy_coding_pkg;

  localparam int SYS_CLK_HZ      = 100_000_000;
  localparam int LINE_BIT_HZ     = 125_000_000;
  localparam int SYNTH_31M25_HZ  = 31_250_000;
  localparam int SYNTH_25M_HZ    = 25_000_000;
  localparam int SYNTH_10M_HZ    = 10_000_000;
  localparam int REF_NORMAL_HZ   = 25_000_000;
  localparam int REF_RMII_HZ     = 50_000_000;

  // strobe spacings in line bits; the 10 MHz strobe is paced in half bits
  localparam int BITS_PER_31M25  = LINE_BIT_HZ / SYNTH_31M25_HZ;
  localparam int BITS_PER_25M    = LINE_BIT_HZ / SYNTH_25M_HZ;
  localparam int HALF_BITS_10M   = (2 * LINE_BIT_HZ) / SYNTH_10M_HZ;

  localparam int OVS_DEFAULT     = 4;
  localparam int LFSR_W          = 11;
  localparam int CG_W            = 5;
  localparam int NIB_W           = 4;
  localparam int LOCK_MATCH_BITS = 32;
  localparam int REF_TIMEOUT_CYC = 16;

  localparam logic [LFSR_W-1:0] LFSR_SEED = 11'h7FF;

  localparam logic [CG_W-1:0] CG_IDLE = 5'h1F;
  localparam logic [CG_W-1:0] CG_J    = 5'h18;
  localparam logic [CG_W-1:0] CG_K    = 5'h11;
  localparam logic [CG_W-1:0] CG_T    = 5'h0D;
  localparam logic [CG_W-1:0] CG_R    = 5'h07;
  localparam logic [CG_W-1:0] CG_H    = 5'h04;

  localparam logic [1:0] MLT3_ZERO = 2'h0;
  localparam logic [1:0] MLT3_POS  = 2'h1;
  localparam logic [1:0] MLT3_NEG  = 2'h3;

  typedef logic [1:0] mlt3_t;

  typedef struct packed {
    logic             last;
    logic             er;
    logic [NIB_W-1:0] d;
  } tx_nibble_t;

  typedef struct packed {
    logic             dv;
    logic             er;
    logic [NIB_W-1:0] d;
  } rx_nibble_t;

  typedef struct packed {
    logic             ok;
    logic [NIB_W-1:0] d;
  } decoded_t;

  localparam logic [CG_W-1:0] DATA_CODES [16] = '{
    5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D
  };

  function automatic logic [CG_W-1:0] enc_4b5b(input logic [NIB_W-1:0] d);
    return DATA_CODES[d];
  endfunction

  function automatic decoded_t dec_5b4b(input logic [CG_W-1:0] c);
    decoded_t r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      if (DATA_CODES[i] == c) begin
        r.ok = 1'b1;
        r.d  = NIB_W'(i);
      end
    end
    return r;
  endfunction

  // keystream bit of x^11 + x^9 + 1, shared by scrambler and descrambler
  function automatic logic key_bit(input logic [LFSR_W-1:0] s);
    return s[10] ^ s[8];
  endfunction

  function automatic mlt3_t mlt3_level(input logic [1:0] phase);
    mlt3_t l;
    l = MLT3_ZERO;
    if (phase == 2'h1) begin
      l = MLT3_POS;
    end else if (phase == 2'h3) begin
      l = MLT3_NEG;
    end
    return l;
  endfunction

endpackage

// *** src/two_entry_buffer.sv ***
// two-entry valid/ready buffer with registered head
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int W = 6
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] head;
  logic [W-1:0] tail;
  logic [1:0]   count;
  logic         push;
  logic         pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = head;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 2'h0;
    end else if (push && !pop) begin
      count <= count + 2'h1;
    end else if (pop && !push) begin
      count <= count - 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      head <= '0;
      tail <= '0;
    end else begin
      if (push && (count == 2'h0 || (count == 2'h1 && pop))) begin
        head <= in_data;
      end else if (pop && count == 2'h2) begin
        head <= tail;
      end
      if (push && ((count == 2'h1 && !pop) || count == 2'h2)) begin
        tail <= in_data;
      end
    end
  end
endmodule

// *** tb/link_partner_model.sv ***
// far-end model: a partner that repeats the received line back after a short delay
`timescale 1ns/100ps
module link_partner_model
  import phy_coding_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  fx_mode,
  input  wire mlt3_t line_in,
  input  wire logic  fx_in,
  output mlt3_t      line_out,
  output logic       fx_out
);
  mlt3_t d0 = MLT3_ZERO;
  mlt3_t d1 = MLT3_ZERO;
  logic  f0 = 1'b0;
  logic  f1 = 1'b0;
  logic  tog = 1'b0;
  always @(posedge sys_clk) begin
    d0  <= line_in;
    d1  <= d0;
    f0  <= fx_in;
    f1  <= f0;
    tog <= ~tog;
  end
  // the unused medium carries changing noise, never a held last value
  assign line_out = fx_mode ? (tog ? MLT3_POS : MLT3_NEG) : d1;
  assign fx_out   = fx_mode ? f1 : tog;
endmodule

// *** tb/phy_coding_path_checker.sv ***
// port-level assertions of the coding path
`timescale 1ns/100ps
module phy_coding_path_checker
  import phy_coding_pkg::*;
#(
  parameter int OVS = OVS_DEFAULT
) (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       fx_mode,
  input wire mlt3_t      line_tx,
  input wire logic       fx_tx_bit,
  input wire rx_nibble_t rx_word,
  input wire logic       rx_valid,
  input wire logic       rx_code_err,
  input wire logic       ref_ok,
  input wire logic       tick_125m,
  input wire logic       tick_31m25,
  input wire logic       tick_25m,
  input wire logic       tick_10m
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] gap;
  logic [3:0] n31;
  logic [3:0] n25;
  logic [3:0] n10;
  logic [3:0] seen;
  mlt3_t      last_nz;
  // history is dropped while the reference is lost, since the bit pace stops then
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap     <= '0;
      n31     <= '0;
      n25     <= '0;
      n10     <= '0;
      seen    <= '0;
      last_nz <= MLT3_ZERO;
    end else begin
      gap  <= tick_125m ? 8'h01 : gap + {7'h00, gap != 8'hFF};
      n31  <= tick_31m25 ? 4'h0 : n31 + {3'h0, tick_125m};
      n25  <= tick_25m ? 4'h0 : n25 + {3'h0, tick_125m};
      n10  <= tick_10m ? 4'h0 : n10 + {3'h0, tick_125m};
      seen <= ref_ok ? (seen | {tick_10m, tick_25m, tick_31m25, tick_125m}) : 4'h0;
      if (line_tx != MLT3_ZERO) begin
        last_nz <= line_tx;
      end
    end
  end
  sequence s_rx_quiet;
    !rx_valid [*8];
  endsequence
  chk_bit_pace: assert property (tick_125m && seen[0] |-> gap == 8'(OVS))
    else $error("bit strobe spacing wrong");
  chk_quarter_tick: assert property (tick_31m25 && seen[1] |-> n31 + {3'h0, tick_125m} == 4'h4)
    else $error("31.25 strobe spacing wrong");
  chk_fifth_tick: assert property (tick_25m && seen[2] |-> n25 + {3'h0, tick_125m} == 4'h5)
    else $error("25 strobe spacing wrong");
  chk_tenth_tick: assert property (tick_10m && seen[3] |->
    (n10 + {3'h0, tick_125m}) inside {4'hC, 4'hD})
    else $error("10 strobe spacing wrong");
  chk_mlt3_via_zero: assert property ($changed(line_tx) |->
    line_tx != 2'h2 && (($past(line_tx) == MLT3_ZERO) != (line_tx == MLT3_ZERO)))
    else $error("line level skipped zero");
  chk_level_alternate: assert property (line_tx != MLT3_ZERO && $past(line_tx) == MLT3_ZERO
    |-> line_tx != last_nz)
    else $error("line level repeated its sign");
  chk_nrzi_mlt3: assert property (!fx_mode && !$past(fx_mode, 4)
    |-> $changed(line_tx) == $changed(fx_tx_bit))
    else $error("line level and line bit disagree");
  chk_fiber_quiet: assert property (fx_mode && $past(fx_mode, 4) |-> line_tx == MLT3_ZERO)
    else $error("line level moves in fiber mode");
  chk_line_bit_pace: assert property ($changed(fx_tx_bit) |-> tick_125m)
    else $error("line bit changed off the bit pace");
  chk_err_word: assert property (rx_code_err |-> rx_valid && rx_word == 6'h30)
    else $error("code error word malformed");
  chk_word_gap: assert property (rx_valid |=> s_rx_quiet)
    else $error("receive words too close");
endmodule

bind phy_coding_path phy_coding_path_checker #(.OVS(OVS)) u_chk (
  .sys_clk     (sys_clk),
  .rst_n       (rst_n),
  .fx_mode     (fx_mode),
  .line_tx     (line_tx),
  .fx_tx_bit   (fx_tx_bit),
  .rx_word     (rx_word),
  .rx_valid    (rx_valid),
  .rx_code_err (rx_code_err),
  .ref_ok      (ref_ok),
  .tick_125m   (tick_125m),
  .tick_31m25  (tick_31m25),
  .tick_25m    (tick_25m),
  .tick_10m    (tick_10m)
);

// *** tb/phy_coding_path_tb_top.sv ***
// self-checking bench of the coding path looped through a partner
`timescale 1ns/100ps
module phy_coding_path_tb_top;
  import phy_coding_pkg::*;
  localparam int OVS_TB = 2;
  logic       sys_clk     = 1'b0;
  logic       rst_n       = 1'b0;
  logic       rmii_mode   = 1'b0;
  logic       fx_mode     = 1'b0;
  logic       ref_clk_25m = 1'b0;
  logic       ref_clk_50m = 1'b0;
  logic       ref_25_on   = 1'b1;
  logic       tx_valid    = 1'b0;
  tx_nibble_t tx_word     = '0;
  logic       tx_ready;
  mlt3_t      line_tx;
  logic       fx_tx_bit;
  mlt3_t      line_rx;
  logic       fx_rx_bit;
  rx_nibble_t rx_word;
  logic       rx_valid;
  logic       rx_code_err;
  logic       rx_locked;
  logic       ref_ok;
  logic [3:0] ticks;
  int         error_cnt    = 0;
  int         total_checks = 0;
  int         err_pulses   = 0;
  bit         full_seen    = 0;
  logic [5:0] rxq[$];

  always #5 sys_clk = ~sys_clk;
  always #20 if (ref_25_on) ref_clk_25m = ~ref_clk_25m;
  // outside party supplies 50 MHz reference
  always #10 ref_clk_50m = ~ref_clk_50m;
  always @(negedge sys_clk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_word);
    if (rx_code_err === 1'b1) err_pulses++;
  end

  phy_coding_path #(.OVS(OVS_TB)) DUT (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .rmii_mode   (rmii_mode),
    .fx_mode     (fx_mode),
    .ref_clk_25m (ref_clk_25m),
    .ref_clk_50m (ref_clk_50m),
    .tx_valid    (tx_valid),
    .tx_ready    (tx_ready),
    .tx_word     (tx_word),
    .line_tx     (line_tx),
    .fx_tx_bit   (fx_tx_bit),
    .line_rx     (line_rx),
    .fx_rx_bit   (fx_rx_bit),
    .rx_word     (rx_word),
    .rx_valid    (rx_valid),
    .rx_code_err (rx_code_err),
    .rx_locked   (rx_locked),
    .ref_ok      (ref_ok),
    .tick_125m   (ticks[0]),
    .tick_31m25  (ticks[1]),
    .tick_25m    (ticks[2]),
    .tick_10m    (ticks[3])
  );
  link_partner_model u_cable (
    .sys_clk  (sys_clk),
    .fx_mode  (fx_mode),
    .line_in  (line_tx),
    .fx_in    (fx_tx_bit),
    .line_out (line_rx),
    .fx_out   (fx_rx_bit)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic bit cond(input int w, input int n);
    case (w)
      0: return rx_locked === 1'b1;
      1: return ref_ok === 1'b1;
      2: return rxq.size() >= n;
      default: return ref_ok === 1'b0;
    endcase
  endfunction
  task automatic wait_for(input int w, input int n, input int bound);
    int i;
    for (i = 0; i < bound && !cond(w, n); i++) @(negedge sys_clk);
    if (i == bound) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, w, n);
      error_cnt++;
      end_of_test();
    end
  endtask
  // words go back to back; a word stays offered until tx_ready is seen
  task automatic send_frame(input int first, input int n, input int err_at);
    int  k;
    int  j;
    bit  rdy;
    rxq.delete();
    @(posedge sys_clk);
    for (k = 0; k < n; k++) begin
      tx_valid <= 1'b1;
      tx_word  <= {k == n - 1, k == err_at, 4'(first + k)};
      rdy = 0;
      for (j = 0; j < 100 && !rdy; j++) begin
        @(negedge sys_clk);
        rdy = (tx_ready === 1'b1);
        if (!rdy) full_seen = 1;
        @(posedge sys_clk);
      end
      if (!rdy) begin
        check(rdy, 1'b1);
        end_of_test();
      end
    end
    tx_valid <= 1'b0;
  endtask
  task automatic check_frame(input int first, input int n, input int err_at);
    int k;
    wait_for(2, n + 1, 3000);
    for (k = 0; k < n; k++) begin
      check(rxq[k], k == err_at ? 8'h30 : {4'h2, 4'(first + k)});
    end
    check(rxq[n], 8'h00);
  endtask

  task automatic t_reset();
    check(tx_ready, 1'b1);
    check(line_tx, MLT3_ZERO);
    check(rx_locked, 1'b0);
    $display("reset test done");
  endtask
  task automatic t_ticks();
    int c[4];
    wait_for(1, 0, 100);
    c = '{default: 0};
    repeat (100 * OVS_TB) begin
      @(negedge sys_clk);
      for (int i = 0; i < 4; i++) c[i] += (ticks[i] === 1'b1);
    end
    check(c[0], 8'd100);
    check(c[1], 8'd25);
    check(c[2], 8'd20);
    check(c[3], 8'd8);
    $display("strobe test done");
  endtask
  task automatic t_frame();
    wait_for(0, 0, 4000);
    check(rx_locked, 1'b1);
    send_frame(0, 16, 16);
    check(full_seen, 1'b1);
    check_frame(0, 16, 16);
    check(err_pulses, 8'd0);
    $display("frame test done");
  endtask
  task automatic t_err();
    send_frame(5, 4, 1);
    check_frame(5, 4, 1);
    check(err_pulses, 8'd1);
    $display("error test done");
  endtask
  task automatic t_rmii();
    @(posedge sys_clk);
    rmii_mode <= 1'b1;
    ref_25_on = 1'b0;
    repeat (40) @(negedge sys_clk);
    check(ref_ok, 1'b1);
    @(posedge sys_clk);
    rmii_mode <= 1'b0;
    wait_for(3, 0, 40);
    check(ref_ok, 1'b0);
    ref_25_on = 1'b1;
    wait_for(1, 0, 100);
    check(ref_ok, 1'b1);
    $display("reference test done");
  endtask
  task automatic t_fx();
    @(posedge sys_clk);
    fx_mode <= 1'b1;
    repeat (100) @(negedge sys_clk);
    check(rx_locked, 1'b1);
    send_frame(9, 5, 5);
    check_frame(9, 5, 5);
    check(line_tx, MLT3_ZERO);
    $display("fiber test done");
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_ticks();
    t_frame();
    t_err();
    t_rmii();
    t_fx();
    end_of_test();
  end
endmodule
